// File: hw/dtg_regs.vh
`ifndef DTG_REGS_VH
`define DTG_REGS_VH

// ============================================================
// Register indices; byte address is four times the index
`define DTG_IDX_FIRST_FREQ 25'h1FF80B0
`define DTG_IDX_MOD_FREQ 25'h1FF80B2
`define DTG_IDX_SECOND_FREQ 25'h1FF80BA
`define DTG_IDX_SWITCH_TIME 25'h1FF80BC
`define DTG_IDX_TOTAL_TIME 25'h1FF80BE
`define DTG_IDX_CONTROL 25'h1FF80A0
`define DTG_IDX_STATUS 25'h1FF80A2

// ============================================================
// Field layout
`define DTG_VAL_MSB 9
`define DTG_VAL_LSB 0
`define DTG_CTRL_PIN_EN_BIT 0
`define DTG_STAT_DUAL_OUT_BIT 0
`define DTG_STAT_MOD_OUT_BIT 1
`define DTG_STAT_SECOND_BIT 2
`define DTG_STAT_WAIT_BIT 3
`define DTG_STAT_PAT_LSB 16
`define DTG_STAT_PAT_MSB 25

// ============================================================
// Reset values
`define DTG_RST_VAL 10'h000
`define DTG_RST_PIN_EN 1'b0

// ============================================================
// Timing: divider stages and pattern timebase
`define DTG_HALF_SHIFT 6
`define DTG_CLK_PERIOD_NS 50
`define DTG_TIMEBASE_NS 102400
`define DTG_TIMEBASE_CYC (`DTG_TIMEBASE_NS / `DTG_CLK_PERIOD_NS)

`endif

// File: hw/dtg_tone_gen.v
`timescale 1ns/1ps
`include "dtg_regs.vh"

// One square-wave tone generator, half period = divisor * 64 clocks
module dtg_tone_gen (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Control
    input wire [9:0] divisor,
    input wire hold_low,
    // Output
    output wire tone_out,
    output wire running
);

reg [9:0] div_r;
reg [15:0] cnt_r;
reg out_r;
wire [15:0] half_cyc;
wire half_end;

// Half period in clocks: divisor * 8 * 8, both halves equal
assign half_cyc = {div_r, 6'h00};
assign half_end = (cnt_r == (half_cyc - 16'h0001));
assign tone_out = out_r;
assign running = (div_r != 10'h000);

// ============================================================
// Divider and output state
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        div_r <= 10'h000;
        cnt_r <= 16'h0000;
        out_r <= 1'b0;
    end else if (div_r == 10'h000) begin
        // Idle: low until a nonzero divisor arrives with hold_low clear
        cnt_r <= 16'h0000;
        out_r <= 1'b0;
        if (divisor != 10'h000 && !hold_low) begin
            div_r <= divisor;
            out_r <= 1'b1;
        end
    end else if (half_end) begin
        cnt_r <= 16'h0000;
        if (out_r) begin
            out_r <= 1'b0;
        end else if (divisor == 10'h000 || hold_low) begin
            // Stop only at a cycle boundary, never mid-pulse
            div_r <= 10'h000;
        end else begin
            // New divisor takes effect at the start of a cycle
            div_r <= divisor;
            out_r <= 1'b1;
        end
    end else begin
        cnt_r <= cnt_r + 16'h0001;
    end
end

endmodule // dtg_tone_gen

// File: hw/dtg_top.v
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "dtg_regs.vh"

// Behaviour
// - Two tone generators, dual-tone and modulating, run independently of each other.
// - Each tone output is a square wave with equal high and low halves.
// - A new frequency value applies only at the start of the next cycle.
// - Modulating tone goes to its pin and to the bell/ringer modulator.
// - Switch and total times count 102.4 us steps, range zero to 104.8 ms.
// - Tone frequency is clock divided by divisor times eight, eight, two.
// - A zero divisor in effect disables the generator and drives it low.
// - Every frequency and time value is a 10-bit read/write field, bits 9:0.
// - Pattern gives first frequency until switch time, then second until total.
// - Zero switch time gives second frequency for the whole pattern.
// - Switch time at or above total gives first frequency throughout.
// - Zero total time clears pattern counters and holds output low after high.
// - Nonzero total time releases the pattern counters and dual-tone generation.
// - Pattern restart at total expiry waits until the tone output is low.
// - Pin enable gates only the pin; the modulator still gets the tone.
module dtg_top (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // Tone outputs
    output wire dual_tone_out,
    output wire modulating_tone_pin,
    output wire modulation_source_tone
);

// ============================================================
// Address helper
function [31:0] dtg_addr;
    input [24:0] idx;
    begin
        dtg_addr = {5'h00, idx, 2'b00};
    end
endfunction

// ============================================================
// Declarations
reg [9:0] first_freq_r;
reg [9:0] first_freq_nxt;
reg [9:0] mod_freq_r;
reg [9:0] mod_freq_nxt;
reg [9:0] second_freq_r;
reg [9:0] second_freq_nxt;
reg [9:0] switch_time_r;
reg [9:0] switch_time_nxt;
reg [9:0] total_time_r;
reg [9:0] total_time_nxt;
reg pin_en_r;
reg pin_en_nxt;
reg wr_pend_r;
reg [31:0] wr_addr_r;
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;
reg [11:0] presc_r;
reg [9:0] pat_r;
reg wait_r;
wire addr_phase;
wire tick;
wire pat_enable;
wire use_second;
wire [9:0] dual_divisor;
wire dual_tone;
wire mod_tone;
wire dual_running;
wire mod_running;
wire [31:0] status_word;

// ============================================================
// Bus slave: zero wait states, always OKAY
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_r;
assign addr_phase = hsel && hready && htrans[1];

// Data-phase write tracking
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 32'h00000000;
    end else if (hready) begin
        wr_pend_r <= addr_phase && hwrite;
        wr_addr_r <= haddr;
    end
end

// Register next values, write lands in its data phase
always @* begin
    first_freq_nxt = first_freq_r;
    mod_freq_nxt = mod_freq_r;
    second_freq_nxt = second_freq_r;
    switch_time_nxt = switch_time_r;
    total_time_nxt = total_time_r;
    pin_en_nxt = pin_en_r;
    if (wr_pend_r) begin
        case (wr_addr_r)
            dtg_addr(`DTG_IDX_FIRST_FREQ):
                first_freq_nxt = hwdata[`DTG_VAL_MSB:`DTG_VAL_LSB];
            dtg_addr(`DTG_IDX_MOD_FREQ):
                mod_freq_nxt = hwdata[`DTG_VAL_MSB:`DTG_VAL_LSB];
            dtg_addr(`DTG_IDX_SECOND_FREQ):
                second_freq_nxt = hwdata[`DTG_VAL_MSB:`DTG_VAL_LSB];
            dtg_addr(`DTG_IDX_SWITCH_TIME):
                switch_time_nxt = hwdata[`DTG_VAL_MSB:`DTG_VAL_LSB];
            dtg_addr(`DTG_IDX_TOTAL_TIME):
                total_time_nxt = hwdata[`DTG_VAL_MSB:`DTG_VAL_LSB];
            dtg_addr(`DTG_IDX_CONTROL):
                pin_en_nxt = hwdata[`DTG_CTRL_PIN_EN_BIT];
            default: begin
                // Unmapped write is ignored
                pin_en_nxt = pin_en_r;
            end
        endcase
    end
end

// Registers
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        first_freq_r <= `DTG_RST_VAL;
        mod_freq_r <= `DTG_RST_VAL;
        second_freq_r <= `DTG_RST_VAL;
        switch_time_r <= `DTG_RST_VAL;
        total_time_r <= `DTG_RST_VAL;
        pin_en_r <= `DTG_RST_PIN_EN;
    end else begin
        first_freq_r <= first_freq_nxt;
        mod_freq_r <= mod_freq_nxt;
        second_freq_r <= second_freq_nxt;
        switch_time_r <= switch_time_nxt;
        total_time_r <= total_time_nxt;
        pin_en_r <= pin_en_nxt;
    end
end

// ============================================================
// Status word showing live generator state
// Bit 0 dual tone level, bit 1 modulating tone level
// Bit 2 second frequency selected for the dual tone
// Bit 3 pattern expired and waiting for a low output
// Bit 4 dual generator running, bit 5 modulating generator running
// Bits 25:16 pattern position in timebase steps
// Read only; writes to this word are ignored
assign status_word = {6'h00, pat_r, 10'h000, mod_running, dual_running,
    wait_r, use_second, mod_tone, dual_tone};

// Read data, taken from next values so a read after a write sees it
// Upper bits of every value word read as zero
// Unmapped addresses read as zero as well
always @* begin
    rdata_nxt = 32'h00000000;
    case (haddr)
        dtg_addr(`DTG_IDX_FIRST_FREQ): rdata_nxt = {22'h000000, first_freq_nxt};
        dtg_addr(`DTG_IDX_MOD_FREQ): rdata_nxt = {22'h000000, mod_freq_nxt};
        dtg_addr(`DTG_IDX_SECOND_FREQ): rdata_nxt = {22'h000000, second_freq_nxt};
        dtg_addr(`DTG_IDX_SWITCH_TIME): rdata_nxt = {22'h000000, switch_time_nxt};
        dtg_addr(`DTG_IDX_TOTAL_TIME): rdata_nxt = {22'h000000, total_time_nxt};
        dtg_addr(`DTG_IDX_CONTROL): rdata_nxt = {31'h00000000, pin_en_nxt};
        dtg_addr(`DTG_IDX_STATUS): rdata_nxt = status_word;
        default: rdata_nxt = 32'h00000000;
    endcase
end

// Read data register, loaded in the address phase of a read
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rdata_r <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
        rdata_r <= rdata_nxt;
    end else if (hready) begin
        rdata_r <= 32'h00000000;
    end
end

// ============================================================
// Pattern timebase and counter
assign pat_enable = (total_time_r != 10'h000);
assign tick = pat_enable && !wait_r
    && (presc_r == `DTG_TIMEBASE_CYC - 1);

// First frequency while below switch time, else second
assign use_second = (pat_r >= switch_time_r);
assign dual_divisor = use_second ? second_freq_r : first_freq_r;

// Shared prescaler, cleared while the pattern is stopped
// Also held at zero while an expired pattern waits for a low output,
// so the next pattern starts with a whole first step
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        presc_r <= 12'h000;
    end else if (!pat_enable || wait_r || tick) begin
        presc_r <= 12'h000;
    end else begin
        presc_r <= presc_r + 12'h001;
    end
end

// Pattern position; restart waits for a low output
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pat_r <= 10'h000;
        wait_r <= 1'b0;
    end else if (!pat_enable) begin
        pat_r <= 10'h000;
        wait_r <= 1'b0;
    end else if (wait_r || pat_r >= total_time_r) begin
        // Expired: hold until the high level has ended
        if (!dual_tone) begin
            pat_r <= 10'h000;
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end else if (tick) begin
        if (pat_r + 10'h001 >= total_time_r) begin
            if (dual_tone) begin
                wait_r <= 1'b1;
                pat_r <= total_time_r;
            end else begin
                pat_r <= 10'h000;
            end
        end else begin
            pat_r <= pat_r + 10'h001;
        end
    end
end

// ============================================================
// Dual-tone generator
dtg_tone_gen u_dual (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor(dual_divisor),
    .hold_low(!pat_enable),
    .tone_out(dual_tone),
    .running(dual_running)
);

// ============================================================
// Modulating-tone generator
dtg_tone_gen u_mod (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor(mod_freq_r),
    .hold_low(1'b0),
    .tone_out(mod_tone),
    .running(mod_running)
);

// ============================================================
// Outputs
assign dual_tone_out = dual_tone;
assign modulation_source_tone = mod_tone;
assign modulating_tone_pin = mod_tone && pin_en_r;

endmodule // dtg_top

// File: test/dtg_top_asserts.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the tone block
module dtg_top_asserts (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Tones
    input wire dual_tone_out,
    input wire modulating_tone_pin,
    input wire modulation_source_tone
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire [1:0] t = {dual_tone_out, modulation_source_tone};
    logic [1:0] prev_r;
    logic rd_r;
    logic [15:0] run_r [2];
    logic [15:0] hi_r [2];
    // Level run lengths, saturating so long idles never wrap
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 2'h0;
            rd_r <= 1'b0;
            run_r <= '{16'h0, 16'h0};
            hi_r <= '{16'h0, 16'h0};
        end else begin
            prev_r <= t;
            rd_r <= hsel && htrans[1] && !hwrite;
            for (int i = 0; i < 2; i++) begin
                run_r[i] <= (t[i] != prev_r[i]) ? 16'h1 :
                    run_r[i] + {15'h0, run_r[i] != 16'hFFFF};
                if (prev_r[i] && !t[i]) begin
                    hi_r[i] <= run_r[i];
                end
            end
        end
    end
    // High half ends after a whole number of 64-clock steps
    sequence s_fall(sig);
        $fell(sig);
    endsequence
    property p_step(sig, logic [15:0] n);
        s_fall(sig) |-> n[5:0] == 6'h0 && n != 16'h0;
    endproperty
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus wait or error");
    a_rdata_idle: assert property (!rd_r |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    a_pin_gated: assert property (modulating_tone_pin |-> modulation_source_tone)
        else $error("pin high without tone");
    a_mod_step: assert property (p_step(modulation_source_tone, run_r[0]))
        else $error("tone high length");
    a_dual_step: assert property (p_step(dual_tone_out, run_r[1]))
        else $error("dual high length");
    a_mod_low_full: assert property ($rose(modulation_source_tone) |-> run_r[0] >= hi_r[0])
        else $error("tone low half short");
    a_dual_low_full: assert property ($rose(dual_tone_out) |-> run_r[1] >= hi_r[1])
        else $error("dual low half short");
    a_dual_high_cap: assert property (prev_r[1] && dual_tone_out |-> run_r[1] < 16'hFFC0)
        else $error("dual high too long");
endmodule // dtg_top_asserts

bind dtg_top dtg_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .dual_tone_out(dual_tone_out), .modulating_tone_pin(modulating_tone_pin),
    .modulation_source_tone(modulation_source_tone));

// File: test/dual_tone_generator_test.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the tone block
module dual_tone_generator_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
    logic [31:0] rq[$], pq[$];
    wire hreadyout, hresp, dual_tone_out, modulating_tone_pin, modulation_source_tone;
    wire [31:0] hrdata;
    wire [2:0] tv = {modulating_tone_pin, dual_tone_out, modulation_source_tone};
    int n_errors = 0, comparisons = 0, hl = 0, ws = 0, i;
    // First, tone, second, switch, total, control, unmapped
    logic [31:0] adr[7] = '{32'h07FE02C0, 32'h07FE02C8, 32'h07FE02E8, 32'h07FE02F0,
        32'h07FE02F8, 32'h07FE0280, 32'h07FE0300};
    int sw[4] = '{1, 0, 5, 2};
    int e1[4] = '{128, 128, 64, 64};

    dtg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dual_tone_out(dual_tone_out),
        .modulating_tone_pin(modulating_tone_pin),
        .modulation_source_tone(modulation_source_tone));

    // Clock
    initial begin
        forever #25 hclk = ~hclk;
    end

    task chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task tmo(input int c);
        if (c >= 20000) begin
            n_errors++;
            results;
        end
    endtask

    task rdy;
        int c;
        for (c = 0; c == 0 || (hreadyout !== 1'b1 && c < 20000); c++) @(posedge hclk);
        tmo(c);
    endtask

    // One single transfer; reads note the expected word
    task xfer(input logic w, input logic [31:0] a, v);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? v : 32'h0;
        if (!w) rq.push_back(v);
        rdy;
    endtask

    task lvl(input logic v);
        int c;
        for (c = 0; tv[ws] !== v && c < 20000; c++) @(negedge hclk);
        tmo(c);
    endtask

    // Note k high halves of n clocks, then wait for them
    task hi(input int n, k);
        int c;
        lvl(1'b0);
        @(negedge hclk);
        repeat (k) pq.push_back(n);
        for (c = 0; pq.size() > 0 && c < 20000; c++) @(negedge hclk);
        tmo(c);
    endtask

    task quiet(input int n);
        logic [31:0] r;
        r = 32'h0;
        repeat (n) begin
            @(negedge hclk);
            r = r + tv[ws];
        end
        chk(r, 32'h0);
    endtask

    // Read data taken at the edge that ends the data phase
    always @(posedge hclk) begin
        if (rd_ph) chk(hrdata, rq.pop_front());
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    // High half lengths of the watched tone
    always @(negedge hclk) begin
        if (tv[ws] === 1'b1) hl++;
        else begin
            if (hl > 0 && pq.size() > 0) chk(hl, pq.pop_front());
            hl = 0;
        end
    end

    initial begin
        d = $urandom(76336);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 7; i++) xfer(1'b0, adr[i], 32'h0);
        for (i = 0; i < 7; i++) begin
            d = $urandom() & 32'hFFFFFC3F;
            xfer(1'b1, adr[i], d);
            xfer(1'b0, adr[i], d & (i == 6 ? 32'h0 : i == 5 ? 32'h1 : 32'h3FF));
            xfer(1'b1, adr[i], 32'h0);
        end
        $display("registers done");
        xfer(1'b1, adr[5], 32'h1);
        xfer(1'b1, adr[1], 32'h1);
        ws = 2;
        hi(64, 2);
        ws = 0;
        hi(64, 2);
        lvl(1'b1);
        xfer(1'b1, adr[1], 32'h3);
        pq.push_back(32'd64);
        pq.push_back(32'd192);
        hi(0, 0);
        xfer(1'b1, adr[5], 32'h0);
        ws = 2;
        quiet(800);
        ws = 0;
        hi(192, 1);
        xfer(1'b1, adr[1], 32'h0);
        repeat (400) @(negedge hclk);
        quiet(800);
        xfer(1'b0, 32'h07FE0288, 32'h4);
        $display("modulating tone done");
        xfer(1'b1, adr[0], 32'h1);
        xfer(1'b1, adr[2], 32'h2);
        ws = 1;
        foreach (sw[k]) begin
            xfer(1'b1, adr[4], 32'h0);
            repeat (300) @(negedge hclk);
            quiet(600);
            xfer(1'b1, adr[3], sw[k]);
            xfer(1'b1, adr[4], 32'h2);
            hi(sw[k] ? 64 : 128, 1);
            repeat (2100) @(negedge hclk);
            hi(e1[k], 1);
            repeat (2100) @(negedge hclk);
            hi(sw[k] ? 64 : 128, 1);
        end
        $display("dual tone done");
        results;
    end
endmodule // dual_tone_generator_test
